// [verilog/dcad_pkg.sv]
// Package for the operand and ALU decode block: register map, field layout,
// opcode and condition encodings, status bit positions and reset values.
// Assumes a single core clock and a plain strobed register port.
package dcad_pkg;
  // Register byte addresses.
  localparam logic [7:0] REG_OPA = 8'h00;
  localparam logic [7:0] REG_OPB = 8'h04;
  localparam logic [7:0] REG_SPEC = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam logic [7:0] REG_INFO = 8'h18;
  localparam logic [7:0] REG_DSP_SPEC = 8'h1c;
  localparam logic [7:0] REG_DSP_DEC = 8'h20;
  localparam logic [7:0] REG_ACCA_LO = 8'h24;
  localparam logic [7:0] REG_ACCA_HI = 8'h28;
  localparam logic [7:0] REG_ACCB_LO = 8'h2c;
  localparam logic [7:0] REG_ACCB_HI = 8'h30;
  // Status bit positions.
  localparam int ST_W = 9;
  localparam int S_C = 0;
  localparam int S_Z = 1;
  localparam int S_OV = 2;
  localparam int S_N = 3;
  localparam int S_DC = 4;
  localparam int S_OA = 5;
  localparam int S_OB = 6;
  localparam int S_SA = 7;
  localparam int S_SB = 8;
  localparam logic [ST_W-1:0] STATUS_RST = 9'h000;
  // Operand specifier field positions.
  localparam int SP_DST = 0;
  localparam int SP_MODE = 8;
  localparam int SP_ACC = 11;
  localparam int SP_SLIT = 12;
  localparam int SP_COND = 16;
  localparam int SPEC_W = 20;
  // DSP specifier field positions.
  localparam int DS_PAIR = 0;
  localparam int DS_SQ = 4;
  localparam int DS_X = 5;
  localparam int DS_Y = 9;
  localparam int DS_XD = 13;
  localparam int DS_YD = 15;
  localparam int DSP_W = 17;
  // Fixed working registers.
  localparam logic [3:0] W_IMPLICIT = 4'h0;
  localparam logic [3:0] W_MUL_BASE = 4'h4;
  localparam logic [3:0] W_X_BASE = 4'h8;
  localparam logic [3:0] W_Y_BASE = 4'ha;
  localparam logic [3:0] W_INDEX = 4'hc;
  localparam int DC_BIT = 4;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dcad_bus_s;

  typedef struct packed {
    logic en;
    logic idx;
    logic [3:0] ptr;
    logic signed [3:0] step;
  } dcad_pfx_s;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD_F = 5'h01, OP_ADD_FW = 5'h02, OP_ADD_L10 = 5'h03,
    OP_ADD_3R = 5'h04, OP_ADD_L5 = 5'h05, OP_ADD_WITH_CARRY_OP_F = 5'h06, OP_ADD_WITH_CARRY_OP_FW = 5'h07,
    OP_ADD_WITH_CARRY_OP_L10 = 5'h08, OP_ADD_WITH_CARRY_OP_3R = 5'h09, OP_ADD_WITH_CARRY_OP_L5 = 5'h0a, OP_ACC_ADD = 5'h0b,
    OP_ASR_F = 5'h0c, OP_ASR_FW = 5'h0d, OP_ASR_WS = 5'h0e, OP_ASR_REG = 5'h0f,
    OP_ASR_L5 = 5'h10, OP_BRA_COND = 5'h11, OP_BRA = 5'h12, OP_BRA_COMP = 5'h13
  } dcad_op_e;

  typedef enum logic [3:0] {
    CC_C = 4'h0, CC_GE = 4'h1, CC_GEU = 4'h2, CC_GT = 4'h3, CC_GTU = 4'h4,
    CC_LE = 4'h5, CC_LEU = 4'h6, CC_LT = 4'h7, CC_LTU = 4'h8
  } dcad_cond_e;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_IND = 3'h1, AM_POSTINC = 3'h2, AM_POSTDEC = 3'h3,
    AM_PREINC = 3'h4, AM_PREDEC = 3'h5, AM_BASEOFS = 3'h6
  } dcad_mode_e;
endpackage : dcad_pkg

// [verilog/dcad_core.sv]
// Operand specifier decode and first ALU slice of a 16-bit DSP core.
// Assumes a single-clock strobed register port; read data one cycle later.
`timescale 1ns/10ps
module dcad_core
  import dcad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dcad_bus_s bus,
  output logic [31:0] rdata,
  output logic done
);
  logic [15:0] opa;
  logic [15:0] opb;
  logic [SPEC_W-1:0] spec;
  logic [DSP_W-1:0] dsp_spec;
  logic [ST_W-1:0] status;
  logic [15:0] result;
  logic [3:0] dst;
  logic dst_file;
  logic [1:0] cycles;
  logic taken;
  logic illegal;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic cmd_wr;
  dcad_op_e cmd_op;
  logic [ST_W-1:0] next_status;
  logic [15:0] next_result;
  logic [3:0] next_dst;
  logic next_dst_file;
  logic [1:0] next_cycles;
  logic next_taken;
  logic next_illegal;
  logic acc_wr;
  logic [39:0] next_acc;
  dcad_pfx_s x_pfx;
  dcad_pfx_s y_pfx;
  logic [3:0] mul_m;
  logic [3:0] mul_n;
  logic pair_bad;
  logic [3:0] x_dst;
  logic [3:0] y_dst;
  logic [15:0] add_b;
  logic add_cin;
  logic [16:0] add_sum;
  logic [4:0] add_nib;
  logic [39:0] acc_src;
  logic [39:0] acc_val;
  logic [40:0] acc_sum;
  logic [4:0] shamt;
  logic cond_ok;
  dcad_mode_e mode;

  // Sets N from the top bit and Z from an all-zero result.
  function automatic logic [ST_W-1:0] nz_upd(input logic [ST_W-1:0] s, input logic [15:0] r);
    nz_upd = s;
    nz_upd[S_N] = r[15];
    nz_upd[S_Z] = (r == 16'h0000);
  endfunction : nz_upd

  // Decodes a four-bit prefetch code: bit 3 picks the pointer, bits 2:0 the step.
  function automatic dcad_pfx_s pfx_dec(input logic [3:0] code, input logic [3:0] base);
    logic [3:0] mag;
    mag = 4'h0;
    pfx_dec.en = 1'b1;
    pfx_dec.idx = 1'b0;
    pfx_dec.ptr = base + {3'h0, code[3]};
    if (code[2:0] == 3'h7) begin
      pfx_dec.idx = code[3];
      pfx_dec.en = code[3];
      pfx_dec.step = 4'sh0;
    end else begin
      mag = code[2] ? {1'b0, code[1:0] + 2'h1, 1'b0} : {1'b0, code[1:0], 1'b0};
      pfx_dec.step = code[2] ? -$signed(mag) : $signed(mag);
    end
  endfunction : pfx_dec

  assign cmd_wr = bus.wr && (bus.addr == REG_CMD);
  assign cmd_op = dcad_op_e'(bus.wdata[4:0]);
  assign mode = dcad_mode_e'(spec[SP_MODE +: 3]);

  // DSP operand decode: multiply pair, prefetch pointers and destinations.
  always_comb begin
    mul_m = W_MUL_BASE + {2'h0, dsp_spec[DS_PAIR+2 +: 2]};
    mul_n = W_MUL_BASE + {2'h0, dsp_spec[DS_PAIR +: 2]};
    if (dsp_spec[DS_SQ]) begin
      pair_bad = (mul_m != mul_n);
    end else begin
      pair_bad = (mul_m >= mul_n);
    end
    x_pfx = pfx_dec(dsp_spec[DS_X +: 4], W_X_BASE);
    y_pfx = pfx_dec(dsp_spec[DS_Y +: 4], W_Y_BASE);
    x_dst = W_MUL_BASE + {2'h0, dsp_spec[DS_XD +: 2]};
    y_dst = W_MUL_BASE + {2'h0, dsp_spec[DS_YD +: 2]};
  end

  // Datapath terms shared by the add, accumulator and shift forms.
  always_comb begin
    unique case (cmd_op)
      OP_ADD_L10, OP_ADD_WITH_CARRY_OP_L10: add_b = {6'h00, opb[9:0]};
      OP_ADD_L5, OP_ADD_WITH_CARRY_OP_L5: add_b = {11'h000, opb[4:0]};
      default: add_b = opb;
    endcase
    add_cin = (cmd_op inside {OP_ADD_WITH_CARRY_OP_F, OP_ADD_WITH_CARRY_OP_FW, OP_ADD_WITH_CARRY_OP_L10, OP_ADD_WITH_CARRY_OP_3R, OP_ADD_WITH_CARRY_OP_L5}) && status[S_C];
    add_sum = {1'b0, opa} + {1'b0, add_b} + {16'h0000, add_cin};
    add_nib = {1'b0, opa[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
    acc_src = {{8{opa[15]}}, opa, 16'h0000};
    if (spec[SP_SLIT+3]) begin
      acc_val = acc_src << (4'(~spec[SP_SLIT +: 4]) + 4'h1);
    end else begin
      acc_val = $signed(acc_src) >>> spec[SP_SLIT +: 3];
    end
    acc_sum = spec[SP_ACC] ? {acc_b[39], acc_b} + {acc_val[39], acc_val} : {acc_a[39], acc_a} + {acc_val[39], acc_val};
    shamt = (cmd_op == OP_ASR_REG) ? {1'b0, opb[3:0]} : opb[4:0];
  end

  // Branch condition evaluation against the current flags.
  always_comb begin
    unique case (dcad_cond_e'(spec[SP_COND +: 4]))
      CC_C, CC_GEU: cond_ok = status[S_C];
      CC_GTU: cond_ok = status[S_C] && !status[S_Z];
      CC_LEU: cond_ok = !status[S_C] || status[S_Z];
      CC_LTU: cond_ok = !status[S_C];
      CC_GE: cond_ok = status[S_N] == status[S_OV];
      CC_GT: cond_ok = !status[S_Z] && (status[S_N] == status[S_OV]);
      CC_LE: cond_ok = status[S_Z] || (status[S_N] != status[S_OV]);
      CC_LT: cond_ok = status[S_N] != status[S_OV];
      default: cond_ok = 1'b0;
    endcase
  end

  // Executes the command written this cycle; results land on the next edge.
  always_comb begin
    next_status = status;
    next_result = result;
    next_dst = spec[SP_DST +: 4];
    next_dst_file = 1'b0;
    next_cycles = CYC_ONE;
    next_taken = 1'b0;
    next_illegal = 1'b0;
    acc_wr = 1'b0;
    next_acc = acc_sum[39:0];
    unique case (cmd_op)
      OP_ADD_F, OP_ADD_FW, OP_ADD_L10, OP_ADD_3R, OP_ADD_L5,
      OP_ADD_WITH_CARRY_OP_F, OP_ADD_WITH_CARRY_OP_FW, OP_ADD_WITH_CARRY_OP_L10, OP_ADD_WITH_CARRY_OP_3R, OP_ADD_WITH_CARRY_OP_L5: begin
        if ((cmd_op inside {OP_ADD_3R, OP_ADD_WITH_CARRY_OP_3R}) && mode > AM_PREDEC) begin
          next_illegal = 1'b1;
        end else begin
          next_result = add_sum[15:0];
          next_status = nz_upd(status, add_sum[15:0]);
          next_status[S_C] = add_sum[16];
          next_status[S_DC] = add_nib[DC_BIT];
          next_status[S_OV] = (opa[15] == add_b[15]) && (add_sum[15] != opa[15]);
          if (add_cin || cmd_op inside {OP_ADD_WITH_CARRY_OP_F, OP_ADD_WITH_CARRY_OP_FW, OP_ADD_WITH_CARRY_OP_L10, OP_ADD_WITH_CARRY_OP_3R, OP_ADD_WITH_CARRY_OP_L5}) begin
            next_status[S_Z] = status[S_Z] && (add_sum[15:0] == 16'h0000);
          end
        end
        if (cmd_op inside {OP_ADD_F, OP_ADD_WITH_CARRY_OP_F}) begin
          next_dst_file = 1'b1;
        end
        if (cmd_op inside {OP_ADD_FW, OP_ADD_WITH_CARRY_OP_FW}) begin
          next_dst = W_IMPLICIT;
        end
      end
      OP_ACC_ADD: begin
        if (mode == AM_IND || mode > AM_BASEOFS) begin
          next_illegal = 1'b1;
        end else begin
          acc_wr = 1'b1;
          next_status[spec[SP_ACC] ? S_OB : S_OA] = !((&acc_sum[39:31]) || !(|acc_sum[39:31]));
          if (acc_sum[40] != acc_sum[39]) begin
            next_status[spec[SP_ACC] ? S_SB : S_SA] = 1'b1;
          end
        end
      end
      OP_ASR_F, OP_ASR_FW, OP_ASR_WS: begin
        if (cmd_op == OP_ASR_WS && mode > AM_PREDEC) begin
          next_illegal = 1'b1;
        end else begin
          next_result = {opa[15], opa[15:1]};
          next_status = nz_upd(status, {opa[15], opa[15:1]});
          next_status[S_C] = opa[0];
          next_status[S_OV] = 1'b0;
        end
        next_dst_file = (cmd_op == OP_ASR_F);
        if (cmd_op == OP_ASR_FW) begin
          next_dst = W_IMPLICIT;
        end
      end
      OP_ASR_REG, OP_ASR_L5: begin
        next_result = 16'($signed(opa) >>> shamt);
        next_status = nz_upd(status, 16'($signed(opa) >>> shamt));
      end
      OP_BRA_COND: begin
        next_taken = cond_ok;
        next_cycles = cond_ok ? CYC_TWO : CYC_ONE;
      end
      OP_BRA, OP_BRA_COMP: begin
        next_taken = 1'b1;
        next_cycles = CYC_TWO;
      end
      default: next_illegal = 1'b1;
    endcase
  end

  // Operand and specifier registers written by software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opa <= 16'h0000;
      opb <= 16'h0000;
      spec <= '0;
      dsp_spec <= '0;
    end else if (bus.wr) begin
      if (bus.addr == REG_OPA) opa <= bus.wdata[15:0];
      if (bus.addr == REG_OPB) opb <= bus.wdata[15:0];
      if (bus.addr == REG_SPEC) spec <= bus.wdata[SPEC_W-1:0];
      if (bus.addr == REG_DSP_SPEC) dsp_spec <= bus.wdata[DSP_W-1:0];
    end
  end

  // Status flags: a command updates them, otherwise software may overwrite them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= STATUS_RST;
    end else if (cmd_wr) begin
      status <= next_status;
    end else if (bus.wr && bus.addr == REG_STATUS) begin
      status <= bus.wdata[ST_W-1:0];
    end
  end

  // Execution results and the one-cycle completion pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= 16'h0000;
      dst <= 4'h0;
      dst_file <= 1'b0;
      cycles <= 2'h0;
      taken <= 1'b0;
      illegal <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= cmd_wr;
      if (cmd_wr) begin
        result <= next_result;
        dst <= next_dst;
        dst_file <= next_dst_file;
        cycles <= next_cycles;
        taken <= next_taken;
        illegal <= next_illegal;
      end
    end
  end

  // Accumulators, 40 bits each.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_a <= 40'h0;
      acc_b <= 40'h0;
    end else if (cmd_wr && acc_wr) begin
      if (spec[SP_ACC]) acc_b <= next_acc;
      else acc_a <= next_acc;
    end
  end

  // Read port: data stand only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk) begin
    if (!rst_n || !bus.rd) begin
      rdata <= 32'h0;
    end else begin
      unique case (bus.addr)
        REG_OPA: rdata <= {16'h0, opa};
        REG_OPB: rdata <= {16'h0, opb};
        REG_SPEC: rdata <= {12'h0, spec};
        REG_STATUS: rdata <= {23'h0, status};
        REG_RESULT: rdata <= {16'h0, result};
        // Pair legality and first multiply register sit above the execution info.
        REG_INFO: rdata <= {17'h0, pair_bad, mul_m, spec[SP_ACC], illegal, taken, cycles, dst_file, dst};
        REG_DSP_SPEC: rdata <= {15'h0, dsp_spec};
        REG_DSP_DEC: rdata <= {mul_n, y_dst, x_dst, y_pfx, x_pfx};
        REG_ACCA_LO: rdata <= acc_a[31:0];
        REG_ACCA_HI: rdata <= {24'h0, acc_a[39:32]};
        REG_ACCB_LO: rdata <= acc_b[31:0];
        REG_ACCB_HI: rdata <= {24'h0, acc_b[39:32]};
        default: rdata <= 32'h0;
      endcase
    end
  end

  // Checks on decode and execution behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_square_pair: assert property (dsp_spec[DS_SQ]
    |-> !pair_bad == ({mul_m, mul_n} inside {8'h44, 8'h55, 8'h66, 8'h77}))
    else $error("square pair legality wrong");
  a_mul_pair_set: assert property (!dsp_spec[DS_SQ]
    |-> !pair_bad == ({mul_m, mul_n} inside {8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67}))
    else $error("multiply pair outside set");
  a_implicit_file_working_reg_dest: assert property (cmd_wr && cmd_op == OP_ADD_FW |=> dst == W_IMPLICIT && !dst_file)
    else $error("implicit W0 destination missed");
  a_x_pointer: assert property (x_pfx.en
    |-> x_pfx.ptr inside {4'h8, 4'h9} && (!x_pfx.idx || x_pfx.ptr == 4'h9))
    else $error("bad X prefetch pointer");
  a_y_pointer: assert property (y_pfx.en
    |-> y_pfx.ptr inside {4'ha, 4'hb} && (!y_pfx.idx || y_pfx.ptr == 4'hb))
    else $error("bad Y prefetch pointer");
  a_pfx_dest: assert property (x_dst inside {[4'h4:4'h7]} && y_dst inside {[4'h4:4'h7]})
    else $error("prefetch destination out of range");
  a_acc_src_mode: assert property (cmd_wr && cmd_op == OP_ACC_ADD && mode == AM_IND
    |=> illegal && $stable(acc_a))
    else $error("plain indirect accepted for accumulator source");
  a_gen_src_mode: assert property (cmd_wr && cmd_op == OP_ASR_WS && mode == AM_BASEOFS
    |=> illegal && $stable(status))
    else $error("base offset accepted for general source");
  a_acc_flags_only: assert property (cmd_wr && cmd_op == OP_ACC_ADD |=> status[4:0] == $past(status[4:0]))
    else $error("accumulator add touched ALU flags");
  a_add_wrap: assert property (cmd_wr && cmd_op == OP_ADD_3R && mode == AM_DIRECT
    && opa == 16'hffff && opb == 16'h0001
    |=> status[S_C] && status[S_Z] && status[S_DC] && !status[S_N] && cycles == CYC_ONE && done)
    else $error("add carry or zero wrong");
  a_asr_carry: assert property (cmd_wr && cmd_op == OP_ASR_F
    |=> status[S_C] == $past(opa[0]) && !status[S_OV] && dst_file)
    else $error("single shift flags wrong");
  a_asr_multi: assert property (cmd_wr && cmd_op == OP_ASR_L5
    |=> status[S_C] == $past(status[S_C]) && status[S_OV] == $past(status[S_OV]))
    else $error("multi shift touched C or OV");
  a_bra_cond: assert property (cmd_wr && cmd_op == OP_BRA_COND
    |=> cycles == (taken ? CYC_TWO : CYC_ONE) && $stable(status))
    else $error("conditional branch timing wrong");
  a_bra_always: assert property (cmd_wr && cmd_op inside {OP_BRA, OP_BRA_COMP}
    |=> cycles == CYC_TWO && taken && $stable(status))
    else $error("unconditional branch timing wrong");
  a_nz_flags: assert property (cmd_wr && cmd_op == OP_ADD_L5
    |=> status[S_Z] == (result == 16'h0000) && status[S_N] == result[15])
    else $error("zero or negative flag wrong");

  c_bra_taken: cover property (cmd_wr && cmd_op == OP_BRA_COND ##1 taken);
  c_acc_sat: cover property (cmd_wr && cmd_op == OP_ACC_ADD ##1 status[S_SA]);
  c_add_with_carry_op_chain: cover property (cmd_wr && cmd_op == OP_ADD_3R ##1 cmd_wr && cmd_op == OP_ADD_WITH_CARRY_OP_3R);
endmodule : dcad_core

// [verif/tb_top.sv]
// Self-checking bench for the operand and ALU decode block.
// Assumes the strobed register port of dcad_core, one 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/10ps
module tb_top
  import dcad_pkg::*;
;
  logic clk;
  logic rst_n;
  dcad_bus_s bus;
  logic [31:0] rdata;
  logic done;
  logic [31:0] res, sto, inf, d;
  int n_mismatch = 0;
  int n_tests = 0;

  // The design under test, with every port driven or watched.
  dcad_core dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .done(done));

  // Free-running 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Counts one comparison and reports it if it does not hold.
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk

  // One write cycle; the strobe drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Loads operands, status and command, then collects result, status and info.
  task automatic exec(input logic [4:0] op, input logic [15:0] a, input logic [15:0] b,
                      input logic [19:0] sp, input logic [8:0] s);
    wr(REG_OPA, {16'h0000, a});
    wr(REG_OPB, {16'h0000, b});
    wr(REG_SPEC, {12'h000, sp});
    wr(REG_STATUS, {23'h000000, s});
    wr(REG_CMD, {27'h0000000, op});
    #1;
    chk(done === 1'b1, "done pulse missing");
    rd(REG_RESULT, res);
    rd(REG_STATUS, sto);
    rd(REG_INFO, inf);
  endtask : exec

  // Expected branch decision for a condition code and status word.
  function automatic logic tk(input logic [3:0] c, input logic [8:0] s);
    logic cy, z, v, n;
    cy = s[S_C];
    z = s[S_Z];
    v = s[S_OV];
    n = s[S_N];
    case (c)
      4'h0: return cy;
      4'h1: return n == v;
      4'h2: return cy;
      4'h3: return !z && n == v;
      4'h4: return cy && !z;
      4'h5: return z || n != v;
      4'h6: return !cy || z;
      4'h7: return n != v;
      default: return !cy;
    endcase
  endfunction : tk

  // Checks one decoded prefetch field against its code and pointer base.
  function automatic logic pok(input logic [9:0] f, input logic [3:0] c, input logic [3:0] b);
    logic [3:0] stp [7];
    stp = '{4'h0, 4'h2, 4'h4, 4'h6, 4'he, 4'hc, 4'ha};
    if (c == 4'h7) return f[9] === 1'b0;
    if (c == 4'hf) return f[9:4] === {2'b11, b + 4'h1};
    return f === {2'b10, b + {3'h0, c[3]}, stp[c[2:0]]};
  endfunction : pok

  // Reset values, unmapped and read-only places, idle read data.
  task automatic t_bus();
    rd(REG_STATUS, d);
    chk(d === 32'h0, "status reset");
    rd(REG_ACCA_LO, d);
    chk(d === 32'h0, "acc reset");
    rd(8'h3c, d);
    chk(d === 32'h0, "unmapped read");
    wr(8'h3c, 32'hffffffff);
    wr(REG_RESULT, 32'h00001234);
    rd(REG_RESULT, d);
    chk(d === 32'h0, "read-only result written");
    wr(REG_OPA, 32'h0000abcd);
    rd(REG_OPA, d);
    chk(d === 32'h0000abcd, "opa readback");
    @(posedge clk);
    #1;
    chk(rdata === 32'h0, "idle read data");
  endtask : t_bus

  // Every add form, then carries, flags, literal masks and destinations.
  task automatic t_add();
    for (int i = 1; i <= 10; i++) begin
      exec(i[4:0], 16'h0001, 16'h0002, 20'h00000, 9'h000);
      chk(res[15:0] === 16'h0003 && inf[6:5] === CYC_ONE, "add form");
    end
    exec(OP_ADD_F, 16'h7fff, 16'h0001, 20'h00000, 9'h000);
    chk(res[15:0] === 16'h8000 && sto[8:0] === 9'h01c, "add overflow");
    chk(inf[4] === 1'b1, "add to file");
    exec(OP_ADD_FW, 16'h0002, 16'h0003, 20'h00005, 9'h000);
    chk(res[15:0] === 16'h0005 && inf[4:0] === 5'h00, "add to implicit reg");
    exec(OP_ADD_WITH_CARRY_OP_3R, 16'hffff, 16'h0000, 20'h0000f, 9'h023);
    chk(res[15:0] === 16'h0000 && sto[8:0] === 9'h033, "add_with_carry_op wrap");
    chk(inf[3:0] === 4'hf, "dest w15");
    exec(OP_ADD_3R, 16'hffff, 16'h0001, 20'h00000, 9'h000);
    chk(res[15:0] === 16'h0000 && sto[8:0] === 9'h013, "add wrap");
    exec(OP_ADD_L10, 16'h0001, 16'hffff, 20'h00000, 9'h000);
    chk(res[15:0] === 16'h0400 && sto[8:0] === 9'h010, "ten_bit_literal mask");
    exec(OP_ADD_WITH_CARRY_OP_L5, 16'h0001, 16'h00ff, 20'h00000, 9'h001);
    chk(res[15:0] === 16'h0021 && sto[8:0] === 9'h010, "five_bit_literal mask");
  endtask : t_add

  // Single and multi-position arithmetic right shifts.
  task automatic t_asr();
    exec(OP_ASR_F, 16'h8001, 16'h0000, 20'h00000, 9'h014);
    chk(res[15:0] === 16'hc000 && sto[8:0] === 9'h019, "asr one");
    chk(inf[6:4] === 3'b011, "asr to file");
    exec(OP_ASR_FW, 16'h0001, 16'h0000, 20'h00003, 9'h004);
    chk(res[15:0] === 16'h0000 && sto[8:0] === 9'h003, "asr zero");
    chk(inf[4:0] === 5'h00, "asr to implicit reg");
    exec(OP_ASR_WS, 16'h0004, 16'h0000, 20'h00007, 9'h000);
    chk(res[15:0] === 16'h0002 && inf[3:0] === 4'h7, "asr source");
    exec(OP_ASR_REG, 16'h8000, 16'h0004, 20'h00009, 9'h015);
    chk(res[15:0] === 16'hf800 && sto[8:0] === 9'h01d, "asr by reg");
    chk(inf[3:0] === 4'h9 && inf[6:5] === CYC_ONE, "asr by reg dest");
    exec(OP_ASR_L5, 16'h8000, 16'h00ff, 20'h00000, 9'h000);
    chk(res[15:0] === 16'hffff && sto[8:0] === 9'h008, "asr lit sign fill");
    exec(OP_ASR_L5, 16'h4000, 16'h00ef, 20'h00000, 9'h005);
    chk(res[15:0] === 16'h0000 && sto[8:0] === 9'h007, "asr lit zero");
  endtask : t_asr

  // Each condition code against several status words, then the plain forms.
  task automatic t_branch();
    logic [8:0] sl [6];
    logic t;
    sl = '{9'h000, 9'h001, 9'h002, 9'h008, 9'h00c, 9'h003};
    for (int c = 0; c < 9; c++) begin
      for (int j = 0; j < 6; j++) begin
        exec(OP_BRA_COND, 16'h0000, 16'h0000, {c[3:0], 16'h0000}, sl[j]);
        t = tk(c[3:0], sl[j]);
        chk(inf[7] === t, "branch decision");
        chk(inf[6:5] === (t ? CYC_TWO : CYC_ONE), "branch cycles");
        chk(sto[8:0] === sl[j], "branch flags");
      end
    end
    exec(OP_BRA, 16'h0000, 16'h0000, 20'h00000, 9'h1ff);
    chk(inf[6:5] === CYC_TWO && sto[8:0] === 9'h1ff, "branch always");
    exec(OP_BRA_COMP, 16'h0003, 16'h0000, 20'h00000, 9'h1ff);
    chk(inf[6:5] === CYC_TWO && sto[8:0] === 9'h1ff, "computed branch");
  endtask : t_branch

  // Shifted signed adds into both accumulators.
  task automatic t_acc();
    exec(OP_ACC_ADD, 16'h0100, 16'h0000, 20'h04000, 9'h01f);
    chk(sto[8:0] === 9'h01f && inf[9] === 1'b0, "acc a flags");
    rd(REG_ACCA_LO, d);
    chk(d === 32'h00100000, "acc a value");
    exec(OP_ACC_ADD, 16'hffff, 16'h0000, 20'h0e800, 9'h000);
    chk(inf[9] === 1'b1 && inf[6:5] === CYC_ONE, "acc b select");
    rd(REG_ACCB_LO, d);
    chk(d === 32'hfffc0000, "acc b low");
    rd(REG_ACCB_HI, d);
    chk(d[7:0] === 8'hff, "acc b high");
    rd(REG_ACCA_LO, d);
    chk(d === 32'h00100000, "acc a kept");
  endtask : t_acc

  // Source modes legal per operand kind, and an undefined op.
  task automatic t_mode();
    for (int m = 0; m < 7; m++) begin
      exec(OP_ADD_3R, 16'h0001, 16'h0001, {9'h000, m[2:0], 8'h00}, 9'h000);
      chk(inf[8] === (m == 6), "general source mode");
      exec(OP_ACC_ADD, 16'h0001, 16'h0000, {9'h000, m[2:0], 8'h00}, 9'h000);
      chk(inf[8] === (m == 1), "acc source mode");
    end
    exec(OP_ADD_3R, 16'h0003, 16'h0004, 20'h00000, 9'h000);
    exec(5'h1f, 16'h0009, 16'h0009, 20'h00000, 9'h0a5);
    chk(inf[8] === 1'b1 && res[15:0] === 16'h0007 && sto[8:0] === 9'h0a5, "illegal op");
    exec(OP_ASR_WS, 16'h0004, 16'h0000, 20'h00600, 9'h0a5);
    chk(inf[8] === 1'b1 && res[15:0] === 16'h0007 && sto[8:0] === 9'h0a5, "base offset shift source");
  endtask : t_mode

  // Prefetch, prefetch destination and pair decode over all codes.
  task automatic t_dsp();
    logic [3:0] ci;
    for (int i = 0; i < 16; i++) begin
      ci = i[3:0];
      wr(REG_DSP_SPEC, {15'h0000, ~ci[1:0], ci[1:0], ~ci, ci, 1'b0, ci});
      rd(REG_DSP_DEC, d);
      chk(pok(d[9:0], ci, W_X_BASE), "x prefetch");
      chk(pok(d[19:10], ~ci, W_Y_BASE), "y prefetch");
      chk(d[23:20] === W_MUL_BASE + {2'b00, ci[1:0]}, "x dest");
      chk(d[27:24] === W_MUL_BASE + {2'b00, ~ci[1:0]}, "y dest");
      chk(d[31:28] === W_MUL_BASE + {2'b00, ci[1:0]}, "pair second reg");
      rd(REG_INFO, d);
      chk(d[14:10] === {ci[3:2] >= ci[1:0], W_MUL_BASE + {2'b00, ci[3:2]}}, "pair legality");
      wr(REG_DSP_SPEC, {27'h0000000, 1'b1, ci});
      rd(REG_INFO, d);
      chk(d[14] === (ci[3:2] != ci[1:0]), "square legality");
    end
  endtask : t_dsp

  // Reset in mid-run clears status and accumulators.
  task automatic t_reset();
    wr(REG_STATUS, 32'h000001ff);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(rdata === 32'h0 && done === 1'b0, "outputs in reset");
    rd(REG_STATUS, d);
    chk(d === 32'h0, "status after reset");
    rd(REG_ACCB_LO, d);
    chk(d === 32'h0, "acc after reset");
  endtask : t_reset

  // Main sequence after a three-cycle reset.
  initial begin
    bus = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_bus();
    t_add();
    t_asr();
    t_branch();
    t_acc();
    t_mode();
    t_dsp();
    t_reset();
    complete_run();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_top
